/* File: logic/pctc_defs.vh */
`ifndef PCTC_DEFS_VH
`define PCTC_DEFS_VH
// ----------------------------------------
// register indices, byte address = 4 * index
// ----------------------------------------
`define PCTC_IDX_CC2_CTL  18'h05444
`define PCTC_IDX_CC2_VA   18'h05446
`define PCTC_IDX_CC2_VB   18'h05448
`define PCTC_IDX_CC2_EN   18'h0544a
`define PCTC_IDX_CC2_FLG  18'h0544c
`define PCTC_IDX_CLK3     18'h0506b
`define PCTC_IDX_CTL3     18'h05460
`define PCTC_IDX_CNT3     18'h05462
`define PCTC_IDX_CC3_CTL  18'h05464
`define PCTC_IDX_CC3_VA   18'h05466
`define PCTC_IDX_CC3_VB   18'h05468
`define PCTC_IDX_CC3_EN   18'h0546a
`define PCTC_IDX_CC3_FLG  18'h0546c
// ----------------------------------------
// writable bits and reset values
// ----------------------------------------
`define PCTC_CCCTL_MASK   16'hf3f3
`define PCTC_EVT_MASK     6'h3f
`define PCTC_CLK_MASK     8'hfd
`define PCTC_CTL_MASK     6'h3d
`define PCTC_RST16        16'h0000
// ----------------------------------------
// field positions
// ----------------------------------------
`define PCTC_CLK_GATE     0
`define PCTC_CLK_SRC      2
`define PCTC_CLK_RATIO    4
`define PCTC_CTL_RUN      0
`define PCTC_CTL_RESET    1
`define PCTC_CTL_SINGLE   2
`define PCTC_CTL_BUF      3
`define PCTC_CTL_PAIR     4
`define PCTC_CC_A_ROLE    0
`define PCTC_CC_A_FLIP    1
`define PCTC_CC_A_WAVE    4
`define PCTC_CC_A_EDGE    6
`define PCTC_CC_B_ROLE    8
`define PCTC_CC_B_FLIP    9
`define PCTC_CC_B_WAVE    12
`define PCTC_CC_B_EDGE    14
// ----------------------------------------
// codes
// ----------------------------------------
`define PCTC_SRC_RC       2'h0
`define PCTC_SRC_SLOW     2'h1
`define PCTC_SRC_FAST     2'h2
`define PCTC_SRC_EXT      2'h3
`define PCTC_RATIO_SLOW   4'h8
`define PCTC_RATIO_NONE   4'hf
`define PCTC_WAVE_SETCLR  2'h1
`define PCTC_WAVE_TOG_A   2'h2
`define PCTC_WAVE_TOG_B   2'h3
`define PCTC_PAIR_OWN     2'h3
`define PCTC_RESP_OKAY    2'h0
`define PCTC_RESP_SLVERR  2'h2
`endif

/* File: logic/pctc_cc_unit.v */
`timescale 1ns/1ns
`default_nettype none
`include "pctc_defs.vh"
module pctc_cc_unit (
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // register access
    input  wire        wr_ctl,
    input  wire        wr_va,
    input  wire        wr_vb,
    input  wire        wr_en,
    input  wire        wr_flg,
    input  wire [15:0] wdata,
    input  wire        buf_on,
    // paired counter
    input  wire [15:0] count,
    input  wire        adv,
    input  wire        restart,
    // pins
    input  wire        cap_a_pin,
    input  wire        cap_b_pin,
    // state
    output wire [15:0] ctl_q,
    output wire [15:0] va_q,
    output wire [15:0] vb_q,
    output wire [5:0]  en_q,
    output wire [5:0]  flg_q,
    output wire [15:0] act_b,
    output wire        event_req,
    output wire        wave_a,
    output wire        wave_b
);
reg  [15:0] ctl_r, va_r, vb_r, acta_r, actb_r;
reg  [5:0]  en_r, flg_r;
reg  [1:0]  cs1_r, cs2_r, cs3_r, wst_r, out_r;
wire [15:0] cmp_a = buf_on ? acta_r : va_r;
wire [15:0] cmp_b = buf_on ? actb_r : vb_r;
wire role_a = ctl_r[`PCTC_CC_A_ROLE];
wire role_b = ctl_r[`PCTC_CC_B_ROLE];
wire [1:0] rise = cs2_r & ~cs3_r;
wire [1:0] fall = ~cs2_r & cs3_r;

function trig;
    input [1:0] sel;
    input       r;
    input       f;
    trig = (sel[0] & r) | (sel[1] & f);
endfunction

function wstep;
    input [1:0] mode;
    input       cur;
    input       ha;
    input       hb;
    case (mode)
        `PCTC_WAVE_SETCLR: wstep = hb ? 1'b0 : (ha ? 1'b1 : cur);
        `PCTC_WAVE_TOG_A:  wstep = cur ^ ha;
        `PCTC_WAVE_TOG_B:  wstep = cur ^ hb;
        default:           wstep = 1'b0;
    endcase
endfunction

// ----------------------------------------
// events
// ----------------------------------------
wire grab_a = role_a & trig(ctl_r[`PCTC_CC_A_EDGE+1:`PCTC_CC_A_EDGE],
                            rise[0], fall[0]);
wire grab_b = role_b & trig(ctl_r[`PCTC_CC_B_EDGE+1:`PCTC_CC_B_EDGE],
                            rise[1], fall[1]);
wire hit_a  = ~role_a & adv & (count == cmp_a);
wire hit_b  = ~role_b & adv & (count == cmp_b);
wire [5:0] evt_set = {grab_b & flg_r[3], grab_a & flg_r[2],
                      grab_b, grab_a, hit_b, hit_a};
wire [5:0] evt_clr = wr_flg ? wdata[5:0] : 6'h00;
wire wa_nxt = wstep(ctl_r[`PCTC_CC_A_WAVE+1:`PCTC_CC_A_WAVE],
                    wst_r[0], hit_a, hit_b);
wire wb_nxt = wstep(ctl_r[`PCTC_CC_B_WAVE+1:`PCTC_CC_B_WAVE],
                    wst_r[1], hit_a, hit_b);

always @(posedge aclk) begin
    if (!aresetn) begin
        ctl_r  <= `PCTC_RST16;
        va_r   <= `PCTC_RST16;
        vb_r   <= `PCTC_RST16;
        acta_r <= `PCTC_RST16;
        actb_r <= `PCTC_RST16;
        en_r   <= 6'h00;
        flg_r  <= 6'h00;
        cs1_r  <= 2'h0;
        cs2_r  <= 2'h0;
        cs3_r  <= 2'h0;
        wst_r  <= 2'h0;
        out_r  <= 2'h0;
    end else begin
        cs1_r <= {cap_b_pin, cap_a_pin};
        cs2_r <= cs1_r;
        cs3_r <= cs2_r;
        if (wr_ctl)
            ctl_r <= wdata & `PCTC_CCCTL_MASK;
        if (wr_en)
            en_r <= wdata[5:0] & `PCTC_EVT_MASK;
        // capture beats a software write in the same cycle
        if (grab_a)
            va_r <= count;
        else if (wr_va)
            va_r <= wdata;
        if (grab_b)
            vb_r <= count;
        else if (wr_vb)
            vb_r <= wdata;
        if (!buf_on || restart) begin
            acta_r <= va_r;
            actb_r <= vb_r;
        end
        flg_r <= (flg_r & ~evt_clr) | evt_set;
        wst_r <= {wb_nxt, wa_nxt};
        out_r <= {wb_nxt ^ ctl_r[`PCTC_CC_B_FLIP],
                  wa_nxt ^ ctl_r[`PCTC_CC_A_FLIP]};
    end
end

assign ctl_q     = ctl_r;
assign va_q      = va_r;
assign vb_q      = vb_r;
assign en_q      = en_r;
assign flg_q     = flg_r;
assign act_b     = cmp_b;
assign event_req = |(flg_r & en_r);
assign wave_a    = out_r[0];
assign wave_b    = out_r[1];
endmodule // pctc_cc_unit
`default_nettype wire

/* File: logic/pctc_channel.v */
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "pctc_defs.vh"
// ----------------------------------------
// ----------------------------------------
module pctc_channel #(
    parameter HAS_RC_SOURCE = 1
) (
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // axi4-lite write address
    input  wire [19:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // axi4-lite write response
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read address
    input  wire [19:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    // axi4-lite read data
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    // count sources
    input  wire        on_chip_rc_source,
    input  wire        slow_crystal_source,
    input  wire        fast_crystal_source,
    input  wire        ext_count_clock,
    // capture pins
    input  wire        cc2_capture_a,
    input  wire        cc2_capture_b,
    input  wire        cc3_capture_a,
    input  wire        cc3_capture_b,
    // other counter channels, same clock
    input  wire [15:0] peer_count_ch0,
    input  wire [15:0] peer_count_ch1,
    input  wire [15:0] peer_count_ch2,
    input  wire [2:0]  peer_advance,
    input  wire [2:0]  peer_restart,
    // waveform outputs and requests
    output wire        cc2_wave_output_a,
    output wire        cc2_wave_output_b,
    output wire        cc3_wave_output_a,
    output wire        cc3_wave_output_b,
    output wire        cc2_event_request,
    output wire        cc3_event_request
);
localparam SL_CC2_CTL = 4'h0;
localparam SL_CC2_VA  = 4'h1;
localparam SL_CC2_VB  = 4'h2;
localparam SL_CC2_EN  = 4'h3;
localparam SL_CC2_FLG = 4'h4;
localparam SL_CLK3    = 4'h5;
localparam SL_CTL3    = 4'h6;
localparam SL_CNT3    = 4'h7;
localparam SL_CC3_CTL = 4'h8;
localparam SL_CC3_VA  = 4'h9;
localparam SL_CC3_VB  = 4'ha;
localparam SL_CC3_EN  = 4'hb;
localparam SL_CC3_FLG = 4'hc;
localparam SL_NONE    = 4'hf;

function [3:0] slot;
    input [17:0] idx;
    case (idx)
        `PCTC_IDX_CC2_CTL: slot = SL_CC2_CTL;
        `PCTC_IDX_CC2_VA:  slot = SL_CC2_VA;
        `PCTC_IDX_CC2_VB:  slot = SL_CC2_VB;
        `PCTC_IDX_CC2_EN:  slot = SL_CC2_EN;
        `PCTC_IDX_CC2_FLG: slot = SL_CC2_FLG;
        `PCTC_IDX_CLK3:    slot = SL_CLK3;
        `PCTC_IDX_CTL3:    slot = SL_CTL3;
        `PCTC_IDX_CNT3:    slot = SL_CNT3;
        `PCTC_IDX_CC3_CTL: slot = SL_CC3_CTL;
        `PCTC_IDX_CC3_VA:  slot = SL_CC3_VA;
        `PCTC_IDX_CC3_VB:  slot = SL_CC3_VB;
        `PCTC_IDX_CC3_EN:  slot = SL_CC3_EN;
        `PCTC_IDX_CC3_FLG: slot = SL_CC3_FLG;
        default:           slot = SL_NONE;
    endcase
endfunction

function [15:0] wmerge;
    input [15:0] old;
    input [15:0] nw;
    input [1:0]  st;
    wmerge = {st[1] ? nw[15:8] : old[15:8], st[0] ? nw[7:0] : old[7:0]};
endfunction

function [13:0] ratio_mask;
    input [3:0] code;
    ratio_mask = (14'h0001 << code) - 14'h0001;
endfunction

// ----------------------------------------
// bus slave
// ----------------------------------------
reg         aw_full_r, w_full_r, bvalid_r, rvalid_r;
reg  [19:0] awaddr_r;
reg  [31:0] wdata_r, rdata_r;
reg  [3:0]  wstrb_r;
reg  [1:0]  bresp_r, rresp_r;
wire [15:0] view [0:15];
wire        wr_go   = aw_full_r & w_full_r & ~bvalid_r;
wire [3:0]  wr_slot = slot(awaddr_r[19:2]);
wire [3:0]  rd_slot = slot(s_axi_araddr[19:2]);
wire [1:0]  st      = wstrb_r[1:0];
wire [15:0] wd      = wdata_r[15:0];
wire [15:0] lanes   = {{8{st[1]}}, {8{st[0]}}};
wire [15:0] unit_wd = (wr_slot == SL_CC2_FLG || wr_slot == SL_CC3_FLG)
                      ? (wd & lanes) : wmerge(view[wr_slot], wd, st);
wire        rd_take = s_axi_arvalid & ~rvalid_r;

assign s_axi_awready = ~aw_full_r;
assign s_axi_wready  = ~w_full_r;
assign s_axi_bvalid  = bvalid_r;
assign s_axi_bresp   = bresp_r;
assign s_axi_arready = ~rvalid_r;
assign s_axi_rvalid  = rvalid_r;
assign s_axi_rdata   = rdata_r;
assign s_axi_rresp   = rresp_r;

always @(posedge aclk) begin
    if (!aresetn) begin
        aw_full_r <= 1'b0;
        w_full_r  <= 1'b0;
        bvalid_r  <= 1'b0;
        rvalid_r  <= 1'b0;
        awaddr_r  <= 20'h00000;
        wdata_r   <= 32'h00000000;
        wstrb_r   <= 4'h0;
        bresp_r   <= `PCTC_RESP_OKAY;
        rresp_r   <= `PCTC_RESP_OKAY;
        rdata_r   <= 32'h00000000;
    end else begin
        if (s_axi_awvalid && !aw_full_r) begin
            aw_full_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_full_r) begin
            w_full_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
        end
        if (wr_go) begin
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= (wr_slot == SL_NONE) ? `PCTC_RESP_SLVERR
                                              : `PCTC_RESP_OKAY;
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
        if (rd_take) begin
            rvalid_r <= 1'b1;
            rdata_r  <= {16'h0000, view[rd_slot]};
            rresp_r  <= (rd_slot == SL_NONE) ? `PCTC_RESP_SLVERR
                                             : `PCTC_RESP_OKAY;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end
end

// ----------------------------------------
// count clock: source select and prescaler
// ----------------------------------------
reg  [7:0]  clk_ctl_r;
reg  [3:0]  src_s1_r, src_s2_r, src_s3_r;
reg  [13:0] pre_r;
wire [1:0]  src_sel = clk_ctl_r[`PCTC_CLK_SRC+1:`PCTC_CLK_SRC];
wire [3:0]  ratio   = clk_ctl_r[`PCTC_CLK_RATIO+3:`PCTC_CLK_RATIO];
wire        gate    = clk_ctl_r[`PCTC_CLK_GATE];
// sources are sampled, so each must stay below half of aclk
wire [3:0]  src_rise = src_s2_r & ~src_s3_r;
wire        rc_ok    = (src_sel != `PCTC_SRC_RC) || (HAS_RC_SOURCE != 0);
wire        src_tick = gate & rc_ok & src_rise[src_sel];
wire        ratio_ok = (ratio != `PCTC_RATIO_NONE) &&
                       !(src_sel == `PCTC_SRC_SLOW &&
                         ratio > `PCTC_RATIO_SLOW);
wire        presc_tick = src_tick & ratio_ok &
                         ((pre_r & ratio_mask(ratio)) ==
                          ratio_mask(ratio));

always @(posedge aclk) begin
    if (!aresetn) begin
        src_s1_r <= 4'h0;
        src_s2_r <= 4'h0;
        src_s3_r <= 4'h0;
        pre_r    <= 14'h0000;
    end else begin
        src_s1_r <= {ext_count_clock, fast_crystal_source,
                     slow_crystal_source, on_chip_rc_source};
        src_s2_r <= src_s1_r;
        src_s3_r <= src_s2_r;
        if (!gate)
            pre_r <= 14'h0000;
        else if (src_tick)
            pre_r <= pre_r + 14'h0001;
    end
end

// ----------------------------------------
// counter channel 3
// ----------------------------------------
reg  [5:0]  cnt_ctl_r;
reg  [15:0] live_count_r;
wire [15:0] cc3_act_b;
wire [15:0] cc3_ctl_q;
wire        counter_run     = cnt_ctl_r[`PCTC_CTL_RUN];
wire        single_pass_sel = cnt_ctl_r[`PCTC_CTL_SINGLE];
wire        compare_buffering_on = cnt_ctl_r[`PCTC_CTL_BUF];
wire [1:0]  paired_counter_select =
                cnt_ctl_r[`PCTC_CTL_PAIR+1:`PCTC_CTL_PAIR];
wire        ctl_wr   = wr_go && wr_slot == SL_CTL3;
wire        zero_wr  = ctl_wr & st[0] & wd[`PCTC_CTL_RESET];
wire        adv3     = presc_tick & counter_run;
// in capture role b sets no period, so the count wraps at 0xffff
wire [15:0] period3  = cc3_ctl_q[`PCTC_CC_B_ROLE] ? 16'hffff : cc3_act_b;
wire        end3     = adv3 & (live_count_r == period3);
wire        restart3 = end3 | zero_wr;
wire [15:0] ctl_new  = wmerge({10'h000, cnt_ctl_r}, wd, st);

always @(posedge aclk) begin
    if (!aresetn) begin
        clk_ctl_r    <= 8'h00;
        cnt_ctl_r    <= 6'h00;
        live_count_r <= `PCTC_RST16;
    end else begin
        if (wr_go && wr_slot == SL_CLK3 && st[0])
            clk_ctl_r <= wd[7:0] & `PCTC_CLK_MASK;
        // a software write beats the single-pass stop
        if (ctl_wr)
            cnt_ctl_r <= ctl_new[5:0] & `PCTC_CTL_MASK;
        else if (end3 && single_pass_sel)
            cnt_ctl_r[`PCTC_CTL_RUN] <= 1'b0;
        if (zero_wr || end3)
            live_count_r <= 16'h0000;
        else if (adv3)
            live_count_r <= live_count_r + 16'h0001;
    end
end

// ----------------------------------------
// pairing of unit cc3
// ----------------------------------------
reg [15:0] cc3_count;
reg        cc3_adv;
reg        cc3_restart;
always @* begin
    case (paired_counter_select)
        2'h0: begin
            cc3_count   = peer_count_ch0;
            cc3_adv     = peer_advance[0];
            cc3_restart = peer_restart[0];
        end
        2'h1: begin
            cc3_count   = peer_count_ch1;
            cc3_adv     = peer_advance[1];
            cc3_restart = peer_restart[1];
        end
        2'h2: begin
            cc3_count   = peer_count_ch2;
            cc3_adv     = peer_advance[2];
            cc3_restart = peer_restart[2];
        end
        default: begin
            cc3_count   = live_count_r;
            cc3_adv     = adv3;
            cc3_restart = restart3;
        end
    endcase
end

// ----------------------------------------
// compare/capture units
// ----------------------------------------
wire [15:0] cc2_ctl_q, cc2_va_q, cc2_vb_q, cc3_va_q, cc3_vb_q;
wire [5:0]  cc2_en_q, cc2_flg_q, cc3_en_q, cc3_flg_q;

pctc_cc_unit u_cc2 (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .wr_ctl    (wr_go && wr_slot == SL_CC2_CTL),
    .wr_va     (wr_go && wr_slot == SL_CC2_VA),
    .wr_vb     (wr_go && wr_slot == SL_CC2_VB),
    .wr_en     (wr_go && wr_slot == SL_CC2_EN),
    .wr_flg    (wr_go && wr_slot == SL_CC2_FLG),
    .wdata     (unit_wd),
    .buf_on    (compare_buffering_on),
    .count     (peer_count_ch2),
    .adv       (peer_advance[2]),
    .restart   (peer_restart[2]),
    .cap_a_pin (cc2_capture_a),
    .cap_b_pin (cc2_capture_b),
    .ctl_q     (cc2_ctl_q),
    .va_q      (cc2_va_q),
    .vb_q      (cc2_vb_q),
    .en_q      (cc2_en_q),
    .flg_q     (cc2_flg_q),
    .act_b     (),
    .event_req (cc2_event_request),
    .wave_a    (cc2_wave_output_a),
    .wave_b    (cc2_wave_output_b)
);

pctc_cc_unit u_cc3 (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .wr_ctl    (wr_go && wr_slot == SL_CC3_CTL),
    .wr_va     (wr_go && wr_slot == SL_CC3_VA),
    .wr_vb     (wr_go && wr_slot == SL_CC3_VB),
    .wr_en     (wr_go && wr_slot == SL_CC3_EN),
    .wr_flg    (wr_go && wr_slot == SL_CC3_FLG),
    .wdata     (unit_wd),
    .buf_on    (compare_buffering_on),
    .count     (cc3_count),
    .adv       (cc3_adv),
    .restart   (cc3_restart),
    .cap_a_pin (cc3_capture_a),
    .cap_b_pin (cc3_capture_b),
    .ctl_q     (cc3_ctl_q),
    .va_q      (cc3_va_q),
    .vb_q      (cc3_vb_q),
    .en_q      (cc3_en_q),
    .flg_q     (cc3_flg_q),
    .act_b     (cc3_act_b),
    .event_req (cc3_event_request),
    .wave_a    (cc3_wave_output_a),
    .wave_b    (cc3_wave_output_b)
);

// ----------------------------------------
// read view, reserved bits zero
// ----------------------------------------
assign view[SL_CC2_CTL] = cc2_ctl_q;
assign view[SL_CC2_VA]  = cc2_va_q;
assign view[SL_CC2_VB]  = cc2_vb_q;
assign view[SL_CC2_EN]  = {10'h000, cc2_en_q};
assign view[SL_CC2_FLG] = {10'h000, cc2_flg_q};
assign view[SL_CLK3]    = {8'h00, clk_ctl_r};
assign view[SL_CTL3]    = {10'h000, cnt_ctl_r};
assign view[SL_CNT3]    = live_count_r;
assign view[SL_CC3_CTL] = cc3_ctl_q;
assign view[SL_CC3_VA]  = cc3_va_q;
assign view[SL_CC3_VB]  = cc3_vb_q;
assign view[SL_CC3_EN]  = {10'h000, cc3_en_q};
assign view[SL_CC3_FLG] = {10'h000, cc3_flg_q};
assign view[4'hd]       = 16'h0000;
assign view[4'he]       = 16'h0000;
assign view[SL_NONE]    = 16'h0000;
endmodule // pctc_channel
`default_nettype wire

/* File: sim/pctc_pins.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// pin side: count source and capture pins
// ----------------------------------------
module pctc_pins (
    // control
    input  wire logic       aclk,
    input  wire logic       run_src,
    input  wire logic [3:0] flip,
    // pins
    output logic            src,
    output logic      [3:0] cap
);
    logic [1:0] ph = 2'h0;
    initial {src, cap} = 5'h00;
    // 3 aclk high, 3 low: slow enough for the 2-flop synchroniser
    always @(posedge aclk) begin
        ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
        if (run_src && ph == 2'h2)
            src <= ~src;
        cap <= cap ^ flip;
    end
endmodule // pctc_pins
`default_nettype wire

/* File: sim/pctc_channel_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
`include "pctc_defs.vh"
// ----------------------------------------
// bus checks
// ----------------------------------------
module pctc_channel_monitor (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // write
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // read
    input wire logic [19:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    localparam logic [19:0] A_CTL3 = {`PCTC_IDX_CTL3, 2'b00};
    localparam logic [19:0] A_FLG3 = {`PCTC_IDX_CC3_FLG, 2'b00};
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer: assert property (s_wr_both |=> ##1 s_axi_bvalid)
        else $error("write response missing");
    a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    a_read_latency: assert property (s_rd_take |=> s_axi_rvalid)
        else $error("read data late");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
    a_upper_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0) else $error("upper set");
    a_reset_bit_zero: assert property (
        (s_rd_take and s_axi_araddr == A_CTL3)
        |=> !s_axi_rdata[1] && s_axi_rdata[15:6] == 10'h0)
        else $error("reset bit read back");
    a_flag_reserved: assert property (
        (s_rd_take and s_axi_araddr == A_FLG3)
        |=> s_axi_rdata[15:6] == 10'h0) else $error("flag reserved set");
    a_unmapped_err: assert property ((s_rd_take and s_axi_araddr == 20'h0)
        |=> s_axi_rresp == 2'h2) else $error("unmapped read okay");
endmodule // pctc_channel_monitor
bind pctc_channel pctc_channel_monitor u_mon (.*);
`default_nettype wire

/* File: sim/tb_pwm_capture_timer_channel.sv */
`timescale 1ns/1ns
`default_nettype none
`include "pctc_defs.vh"
module tb_pwm_capture_timer_channel;
    logic        aclk, aresetn, run_src, wl;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready;
    logic [19:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, rd_v;
    logic [3:0]  s_axi_wstrb, flip;
    logic [15:0] peer_count_ch0, peer_count_ch1, peer_count_ch2, d;
    logic [2:0]  peer_advance, peer_restart;
    logic [1:0]  rs;
    logic [17:0] ix;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, src;
    wire         s_axi_arready, s_axi_rvalid, cc2_event_request;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire  [3:0]  cap;
    wire         on_chip_rc_source, slow_crystal_source, cc3_event_request;
    wire         fast_crystal_source, ext_count_clock;
    wire         cc2_capture_a, cc2_capture_b, cc3_capture_a, cc3_capture_b;
    wire         cc2_wave_output_a, cc2_wave_output_b;
    wire         cc3_wave_output_a, cc3_wave_output_b;
    int          num_errors, num_checks, cyc, tog, i, j, n;
    assign {on_chip_rc_source, slow_crystal_source} = {2{src}};
    assign {fast_crystal_source, ext_count_clock} = {2{src}};
    assign {cc3_capture_b, cc3_capture_a, cc2_capture_b, cc2_capture_a} = cap;
    pctc_channel uut (.*);
    pctc_pins u_pins (.*);
    localparam logic [17:0] CTL = `PCTC_IDX_CTL3, CNT = `PCTC_IDX_CNT3;
    localparam logic [17:0] FLG = `PCTC_IDX_CC3_FLG, CCC = `PCTC_IDX_CC3_CTL;
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        wl <= cc3_wave_output_a;
        if (cc3_wave_output_a !== wl)
            tog <= tog + 1;
        if (aresetn)
            {peer_count_ch0, peer_count_ch1, peer_count_ch2, peer_advance,
             peer_restart} <= {$urandom, 22'($urandom)};
        // ceiling: the run needs about 3000 cycles
        if (cyc == 30000) begin
            num_errors++;
            end_sim;
        end
    end
    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input [31:0] e, input [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(input [17:0] a, input [15:0] v);
        @(posedge aclk);
        s_axi_awaddr <= {a, 2'b00};
        s_axi_wdata <= {16'h0, v};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        rs = s_axi_bresp;
    endtask
    task automatic rd(input [17:0] a);
        @(posedge aclk);
        s_axi_araddr <= {a, 2'b00};
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        {rd_v, rs} = {s_axi_rdata, s_axi_rresp};
    endtask
    task automatic pulse(input [3:0] f);
        flip <= f;
        @(posedge aclk);
        flip <= 4'h0;
        repeat (8) @(posedge aclk);
    endtask
    // readback of a write
    function automatic [31:0] rb(input [17:0] a, input [15:0] v);
        case (a)
            CCC: rb = v & 16'hf3f3;
            `PCTC_IDX_CC3_EN: rb = v & 16'h003f;
            FLG: rb = 32'h0;
            default: rb = v;
        endcase
    endfunction
    // count after 480 cycles, a tick per 6
    function automatic logic near(input [31:0] g, input int k);
        int e;
        e = k ? 480 / (6 << (k - 1)) : 0;
        near = (g + 3 >= e) && (g <= e + (k ? 3 : 0));
    endfunction
    initial begin
        void'($urandom(32'h98960b9d));
        {aresetn, run_src, flip, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready, peer_advance} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, peer_restart} = '0;
        {peer_count_ch0, peer_count_ch1, peer_count_ch2} = '0;
        s_axi_wstrb = 4'hf;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 7; i++) begin
            rd(18'h05460 + 18'(2 * i));
            chk("reset value", 32'h0, rd_v);
        end
        rd(18'h0);
        chk("unmapped read", 32'h2, 32'(rs));
        for (i = 0; i < 10; i++) begin
            ix = 18'h05464 + 18'(2 * (i % 5));
            d = (i < 5) ? 16'hffff : 16'($urandom);
            wr(ix, d);
            rd(ix);
            chk("readback", rb(ix, d), rd_v);
        end
        wr(CTL, 16'hfffe);
        rd(CTL);
        chk("counter control", 32'h3c, rd_v);
        wr(CCC, 16'h0020);
        wr(`PCTC_IDX_CC3_VB, 16'hffff);
        run_src <= 1'b1;
        for (i = 0; i < 4; i++) begin
            wr(`PCTC_IDX_CLK3, (i == 0) ? 16'h0c : 16'h0d + 16'((i - 1) << 4));
            wr(CTL, 16'h0033);
            repeat (480) @(posedge aclk);
            wr(CTL, 16'h0030);
            rd(CNT);
            chk("count window", 32'h1, 32'(near(rd_v, i)));
        end
        wr(`PCTC_IDX_CLK3, 16'h000d);
        wr(`PCTC_IDX_CC3_VA, 16'h0002);
        wr(`PCTC_IDX_CC3_VB, 16'h0005);
        wr(`PCTC_IDX_CC3_EN, 16'h0003);
        n = tog;
        wr(CTL, 16'h0033);
        repeat (200) @(posedge aclk);
        chk("request", 32'h1, 32'(cc3_event_request));
        chk("wave toggles", 32'h1, 32'(tog - n > 2));
        rd(CNT);
        chk("count bound", 32'h1, 32'(rd_v < 6));
        wr(CTL, 16'h0030);
        rd(FLG);
        chk("match flags", 32'h3, rd_v);
        wr(FLG, 16'h0003);
        rd(FLG);
        chk("flags cleared", 32'h0, rd_v);
        chk("request off", 32'h0, 32'(cc3_event_request));
        wr(CTL, 16'h0037);
        repeat (100) @(posedge aclk);
        rd(CTL);
        chk("single pass end", 32'h34, rd_v);
        rd(CNT);
        chk("single pass count", 32'h0, rd_v);
        wr(CTL, 16'h0031);
        for (i = 0; i < 4; i++) begin
            wr(CCC, 16'h0141 | 16'(i << 14));
            for (j = 0; j < 2; j++) begin
                wr(FLG, 16'h003f);
                pulse(4'hc);
                rd(FLG);
                chk("grab b", 32'(i == 3 || i == 1 + j), 32'(rd_v[3]));
            end
        end
        wr(FLG, 16'h003f);
        for (i = 0; i < 3; i++)
            pulse(4'h4);
        rd(FLG);
        chk("overrun a", 32'h14, rd_v & 32'h14);
        end_sim;
    end
endmodule // tb_pwm_capture_timer_channel
`default_nettype wire
